//--- dca_arbiter.sv
// D-channel and C/I0 access arbiter on a frame-based serial TDM bus.
// Assumes an open-drain upstream line with a pull-up outside, bit clock
// and frame sync from pins, and S-bus D bits from local logic.
// Summary of operation
// (R01) Address arbitration runs only with mode 00x, in channel 2 last octet.
// (R02) Software request bit set makes the device contend, pulling the line low.
// (R03) Bus-accessed bit is sampled first; a one means bus free.
// (R04) Send 3-bit address; a one read back as zero withdraws at once.
// (R05) Lowest address wins; winner pulls bus-accessed bit low.
// (R06) Owner keeps bus-accessed bit low until its request is dropped.
// (R07) After winning, contend again only after two successive bus-free frames.
// (R08) With no requester the address field idles at all ones.
// (R09) Software should clear its request bit when access is no longer needed.
// (R10) Mode 0x1 drives stop/go downstream: one is stop, zero is go.
// (R11) Software picks intelligent NT transceiver mode and mode field 001.
// (R12) Count upstream D ones; at threshold with request grant and invert echo.
// (R13) Threshold is 8 or 10 after abort, 9 or 11 after success.
// (R14) No idle state; start in Ready with stop and plain echo.
// (R15) D-channel inhibit enters local access without bus-accessed low.
// (R16) Transceiver reset or disable holds Ready with stop.
// (R17) A local source checks the bit and arbitrates before driving it, except via D-channel inhibit (R15), which skips both.
// (R18) Bus-accessed back to one returns plain echo and stop (Ready).
// (R19) Ready to S-access also needs a ones count of at least two.
// (R20) S-bus D zero starts S-access; S-bus D bits pass upstream unchanged.
`timescale 1ns/1ps
module dca_arbiter import dca_pkg::*; #(
   parameter int FRAME_BITS = FRAME_BITS_DEF
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // TDM pins
   input wire logic i_dcl,
   input wire logic i_fsc,
   input wire logic i_du,
   output logic o_du,
   output logic o_du_oe_n,
   output logic o_dd,
   // Configuration
   input wire dca_cfg_t i_cfg,
   // S-bus D bits in
   input wire logic i_s_dvalid,
   input wire logic i_s_dbit,
   output logic o_s_dready,
   // Echo and status
   output dca_echo_t o_echo,
   output logic o_stop_go,
   output logic o_tic_owned,
   output dca_arb_t o_state
);
   localparam int BW = $clog2(FRAME_BITS);
   localparam logic [BW-1:0] LAST_IDX = BW'(FRAME_BITS - 1);
   localparam logic [BW-1:0] BAC_I = BW'(BAC_IDX);
   localparam logic [BW-1:0] SG_I = BW'(SG_IDX);
   localparam logic [BW-1:0] TBA_I0 = BW'(TBA_IDX0);
   localparam logic [BW-1:0] TBA_IN = BW'(TBA_IDX0 + TBA_W);
   localparam logic [BW-1:0] D_I0 = BW'(D_SLOT_FIRST);
   localparam logic [BW-1:0] D_IN = BW'(D_SLOT_FIRST + D_SLOT_W);
   localparam logic [1:0] TBA_LAST = 2'(TBA_LAST_OFF);

   typedef struct packed {
      logic dcl_prev;
      logic fsc_prev;
      logic fsc_pend;
      logic [BW-1:0] bit_i;
      logic du_oe_n;
      logic dd;
      logic sg;
      dca_arb_t st;
      logic [3:0] ones;
      logic last_ok;
      logic abort;
      logic bac_low;
      logic cont;
      logic lost;
      logic own;
      logic lowpri;
      logic [1:0] free_cnt;
      dca_echo_t echo;
   } dca_arb_st_t;

   dca_arb_st_t r_q, r_d;
   logic [2:0] pin_s;
   logic dcl_s;
   logic fsc_s;
   logic du_s;
   logic rise;
   logic fall;
   logic tic_en;
   logic sg_en;
   logic [3:0] thr;
   logic [BW-1:0] nidx;
   logic [1:0] toff;
   logic [1:0] soff;
   logic abit;
   logic req_local;
   logic f_valid;
   logic f_data;
   logic f_pop;

   // ---------------------------------------------------------------
   // Pin synchronisers and S-bus buffer
   // ---------------------------------------------------------------
   dca_sync #(.W(3)) u_sync (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_async({i_dcl, i_fsc, i_du}),
      .o_sync(pin_s)
   );
   assign {dcl_s, fsc_s, du_s} = pin_s;

   dca_fifo #(.W(1), .DEPTH(2)) u_fifo (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_wvalid(i_s_dvalid),
      .i_wdata(i_s_dbit),
      .o_wready(o_s_dready),
      .o_rvalid(f_valid),
      .o_rdata(f_data),
      .i_rready(f_pop)
   );

   assign rise = dcl_s && !r_q.dcl_prev;
   assign fall = !dcl_s && r_q.dcl_prev;
   assign tic_en = (i_cfg.mode[2:1] == DIM_TIC_HI);
   assign sg_en = !i_cfg.mode[2] && i_cfg.mode[0];
   assign thr = (i_cfg.prio10 ? N_PRIO10 : N_PRIO8)
      + {3'h0, r_q.last_ok}; // R13
   assign nidx = r_q.fsc_pend ? '0
      : (r_q.bit_i == LAST_IDX) ? '0 : BW'(r_q.bit_i + 1'b1);
   assign toff = 2'(nidx - TBA_I0);
   assign soff = 2'(r_q.bit_i - TBA_I0);
   assign abit = i_cfg.addr[TBA_LAST - (fall ? soff : toff)];
   assign req_local = r_q.bac_low || i_cfg.inhibit;
   // Drained every D slot so S-bus bits never back up outside access
   assign f_pop = rise && (nidx >= D_I0) && (nidx < D_IN) && f_valid;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      r_d = r_q;
      r_d.dcl_prev = dcl_s;
      r_d.fsc_prev = fsc_s;
      r_d.echo.valid = 1'b0;
      if (fsc_s && !r_q.fsc_prev) begin
         r_d.fsc_pend = 1'b1;
      end

      // Drive side: set up the next bit cell
      if (rise) begin
         r_d.fsc_pend = 1'b0;
         r_d.bit_i = nidx;
         r_d.du_oe_n = 1'b1; // R08
         r_d.dd = 1'b1;
         if (nidx == SG_I && sg_en) begin
            r_d.dd = r_q.sg; // R10
         end
         if (nidx == BAC_I && r_q.own) begin
            r_d.du_oe_n = 1'b0; // R05 R06
         end
         if (nidx >= TBA_I0 && nidx < TBA_IN && r_q.cont && !abit) begin
            r_d.du_oe_n = 1'b0; // R04
         end
         if (f_pop && r_q.st == ST_SACC && !f_data) begin
            r_d.du_oe_n = 1'b0; // R20
         end
      end

      // Sample side: read back the current bit cell
      if (fall) begin
         if (r_q.bit_i == BAC_I) begin
            r_d.bac_low = !du_s;
            if (r_q.own && !i_cfg.bac_req) begin
               r_d.own = 1'b0;
            end
            if (du_s && !r_q.own) begin
               if (r_q.free_cnt + 1'b1 >= FREE_FRAMES) begin
                  r_d.lowpri = 1'b0; // R07
               end
               r_d.free_cnt = (r_q.free_cnt == FREE_FRAMES)
                  ? FREE_FRAMES : 2'(r_q.free_cnt + 1'b1);
            end else begin
               r_d.free_cnt = '0;
            end
            // R01 R02 R03
            if (tic_en && i_cfg.bac_req && du_s && !r_q.own
                  && !r_q.lowpri) begin
               r_d.cont = 1'b1;
               r_d.lost = 1'b0;
            end
         end
         if (r_q.bit_i >= TBA_I0 && r_q.bit_i < TBA_IN && r_q.cont) begin
            if (abit && !du_s) begin
               r_d.cont = 1'b0; // R04
               r_d.lost = 1'b1;
            end else if (soff == TBA_LAST) begin
               r_d.cont = 1'b0; // R05 R07
               r_d.own = 1'b1;
               r_d.lowpri = 1'b1;
               r_d.free_cnt = '0;
            end
         end
         if (r_q.bit_i >= D_I0 && r_q.bit_i < D_IN) begin
            r_d.ones = !du_s ? '0 : (r_q.ones == ONES_MAX) ? ONES_MAX
               : 4'(r_q.ones + 1'b1); // R12
            r_d.echo.valid = 1'b1;
            r_d.echo.value = du_s ^ (r_q.st == ST_LOCAL); // R12 R14
         end
      end

      // Stop/go arbiter
      unique case (r_q.st)
         ST_READY: begin
            if (req_local && r_q.ones >= thr) begin
               r_d.st = ST_LOCAL; // R12 R15
               r_d.abort = 1'b0;
            end else if (f_valid && !f_data && r_q.ones >= N_STRAY) begin
               r_d.st = ST_SACC; // R19 R20
            end
         end
         ST_LOCAL: begin
            if (r_q.bac_low && r_q.ones >= ONES_ABORT) begin
               r_d.abort = 1'b1;
            end
            if (!req_local) begin
               r_d.st = ST_READY; // R18
               r_d.last_ok = !r_q.abort;
            end
         end
         ST_SACC: begin
            if (r_q.ones >= thr) begin
               r_d.st = ST_READY;
               r_d.last_ok = 1'b1;
            end
         end
      endcase
      if (i_cfg.s_reset || i_cfg.s_disable || !sg_en) begin
         r_d.st = ST_READY; // R16
      end
      r_d.sg = (r_d.st != ST_LOCAL); // R10 R14
      if (!tic_en) begin
         r_d.cont = 1'b0;
         r_d.own = 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         r_q <= '0;
         r_q.du_oe_n <= 1'b1;
         r_q.dd <= 1'b1;
         r_q.sg <= 1'b1;
         r_q.st <= ST_READY; // R14
      end else begin
         r_q <= r_d;
      end
   end

   assign o_du = 1'b0;
   assign o_du_oe_n = r_q.du_oe_n;
   assign o_dd = r_q.dd;
   assign o_echo = r_q.echo;
   assign o_stop_go = r_q.sg;
   assign o_tic_owned = r_q.own;
   assign o_state = r_q.st;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);

   local_entry_a: assert property ( // R12
      r_q.st == ST_READY ##1 r_q.st == ST_LOCAL |->
      $past(r_q.ones) >= $past(thr) && $past(req_local))
      else $error("local access entered below threshold");
   stray_guard_a: assert property ( // R19
      r_q.st == ST_READY ##1 r_q.st == ST_SACC |->
      $past(r_q.ones) >= N_STRAY)
      else $error("S-access entered with too few ones");
   forced_ready_a: assert property ( // R16
      (i_cfg.s_reset || i_cfg.s_disable) |=> r_q.st == ST_READY && r_q.sg)
      else $error("reset or disable did not hold Ready");
   local_release_a: assert property ( // R18
      r_q.st == ST_LOCAL && !req_local |=> r_q.st == ST_READY && r_q.sg)
      else $error("released access did not return to Ready");
   bac_hold_a: assert property ( // R06
      rise && nidx == BAC_I && r_q.own |=> !o_du_oe_n)
      else $error("owner did not pull bus-accessed bit low");
   addr_withdraw_a: assert property ( // R04
      fall && r_q.cont && r_q.bit_i >= TBA_I0 && r_q.bit_i < TBA_IN
      && abit && !du_s |=> !r_q.cont && !r_q.own)
      else $error("contender kept going after losing a bit");
   low_prio_a: assert property ( // R07
      $rose(r_q.cont) |-> !$past(r_q.lowpri))
      else $error("contended while in lower priority class");
   echo_inv_a: assert property ( // R12
      fall && r_q.bit_i >= D_I0 && r_q.bit_i < D_IN |=> o_echo.valid
      && o_echo.value == ($past(du_s) ^ ($past(r_q.st) == ST_LOCAL)))
      else $error("echo bit wrong for arbiter state");
   sg_out_a: assert property ( // R10
      rise && nidx == SG_I && sg_en |=> o_dd == $past(r_q.sg))
      else $error("stop/go not placed on downstream line");

   local_seen_c: cover property (r_q.st == ST_LOCAL ##1 r_q.st == ST_READY);
   sacc_seen_c: cover property (r_q.st == ST_READY ##1 r_q.st == ST_SACC);
   tic_won_c: cover property ($rose(r_q.own));
   tic_lost_c: cover property ($rose(r_q.lost));
endmodule // dca_arbiter

//--- dca_fifo.sv
// Small valid/ready buffer for S-bus D-channel bits.
// Assumes writer and reader on the same clock.
`timescale 1ns/1ps
module dca_fifo import dca_pkg::*; #(
   parameter int W = 1,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // Write side
   input wire logic i_wvalid,
   input wire logic [W-1:0] i_wdata,
   output logic o_wready,
   // Read side
   output logic o_rvalid,
   output logic [W-1:0] o_rdata,
   input wire logic i_rready
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic [CW-1:0] cnt;
      logic full;
      logic empty;
      logic wready;
   } dca_fifo_st_t;

   dca_fifo_st_t r_q, r_d;
   logic do_w;
   logic do_r;

   always_comb begin
      r_d = r_q;
      do_w = i_wvalid && !r_q.full;
      do_r = i_rready && !r_q.empty;
      if (do_w) begin
         r_d.mem[r_q.wp] = i_wdata;
         r_d.wp = (r_q.wp == PW'(DEPTH - 1)) ? '0 : PW'(r_q.wp + 1'b1);
      end
      if (do_r) begin
         r_d.rp = (r_q.rp == PW'(DEPTH - 1)) ? '0 : PW'(r_q.rp + 1'b1);
      end
      if (do_w && !do_r) begin
         r_d.cnt = CW'(r_q.cnt + 1'b1);
      end else if (do_r && !do_w) begin
         r_d.cnt = CW'(r_q.cnt - 1'b1);
      end
      r_d.full = (r_d.cnt == CW'(DEPTH));
      r_d.empty = (r_d.cnt == '0);
      // Ready kept in its own flop so the port is registered
      r_d.wready = !r_d.full;
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         r_q <= '0;
         r_q.empty <= 1'b1;
         r_q.wready <= 1'b1;
      end else begin
         r_q <= r_d;
      end
   end

   assign o_wready = r_q.wready;
   assign o_rvalid = !r_q.empty;
   assign o_rdata = r_q.mem[r_q.rp];
endmodule // dca_fifo

//--- dca_pkg.sv
// Constants and types shared by the D-channel access arbiter files.
// Assumes a serial TDM frame of bit cells, MSB of each octet sent first.
package dca_pkg;
   // ---------------------------------------------------------------
   // Frame layout
   // ---------------------------------------------------------------
   localparam int FRAME_BITS_DEF = 96;
   localparam int TIC_OCT_FIRST = 88;
   localparam int BAC_BIT = 5;
   localparam int TBA_MSB = 4;
   localparam int TBA_W = 3;
   localparam int D_SLOT_FIRST = 24;
   localparam int D_SLOT_W = 2;
   localparam int BAC_IDX = TIC_OCT_FIRST + 7 - BAC_BIT;
   localparam int SG_IDX = BAC_IDX;
   localparam int TBA_IDX0 = TIC_OCT_FIRST + 7 - TBA_MSB;
   localparam int TBA_LAST_OFF = TBA_W - 1;

   // ---------------------------------------------------------------
   // Counts and mode codes
   // ---------------------------------------------------------------
   localparam logic [3:0] N_PRIO8 = 4'h8;
   localparam logic [3:0] N_PRIO10 = 4'hA;
   localparam logic [3:0] N_STRAY = 4'h2;
   localparam logic [3:0] ONES_ABORT = 4'h7;
   localparam logic [3:0] ONES_MAX = 4'hF;
   localparam logic [1:0] FREE_FRAMES = 2'h2;
   localparam logic [1:0] DIM_TIC_HI = 2'h0;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {ST_READY, ST_LOCAL, ST_SACC} dca_arb_t;

   typedef struct packed {
      logic [2:0] mode;
      logic prio10;
      logic inhibit;
      logic s_reset;
      logic s_disable;
      logic bac_req;
      logic [2:0] addr;
   } dca_cfg_t;

   typedef struct packed {
      logic valid;
      logic value;
   } dca_echo_t;
endpackage

//--- dca_sync.sv
// Two-flop synchroniser for asynchronous pin inputs.
// Assumes nothing but the local clock and synchronous reset.
`timescale 1ns/1ps
module dca_sync import dca_pkg::*; #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // Data
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } dca_sync_st_t;

   dca_sync_st_t r_q, r_d;

   always_comb begin
      r_d = r_q;
      r_d.s1 = i_async;
      r_d.s2 = r_q.s1;
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   assign o_sync = r_q.s2;
endmodule // dca_sync

//--- dca_tdm_model.sv
// Far-end model: bit clock, frame sync and an external TIC contender.
// Assumes the device drives the upstream line open-drain, pull-up here.
`timescale 1ns/1ps
module dca_tdm_model import dca_pkg::*; (
   // Device side
   input wire logic i_du_oe_n,
   input wire logic i_du,
   // Scenario control
   input wire logic i_req,
   input wire logic [2:0] i_addr,
   input wire logic i_dval,
   // Link
   output logic o_dcl,
   output logic o_fsc,
   output logic o_wire,
   output logic [6:0] o_idx
);
   logic drv_q;
   logic cont_q;
   int k;
   // Wired-AND upstream line
   assign o_wire = drv_q & (i_du_oe_n | i_du);
   initial begin
      o_dcl = 1'b0;
      o_fsc = 1'b0;
      o_idx = 7'(FRAME_BITS_DEF - 1);
      drv_q = 1'b1;
      cont_q = 1'b0;
      forever begin
         #32;
         o_dcl = 1'b1;
         o_idx = (o_idx == 7'(FRAME_BITS_DEF - 1)) ? 7'h00
            : o_idx + 7'h01;
         k = o_idx;
         o_fsc = 1'b0;
         drv_q = 1'b1;
         if (k >= D_SLOT_FIRST && k < D_SLOT_FIRST + D_SLOT_W)
            drv_q = i_dval;
         if (cont_q && k >= TBA_IDX0 && k <= TBA_IDX0 + TBA_LAST_OFF)
            drv_q = i_addr[TBA_IDX0 + TBA_LAST_OFF - k];
         #32;
         o_dcl = 1'b0;
         if (k == BAC_IDX)
            cont_q = i_req & o_wire;
         else if (cont_q && drv_q && !o_wire)
            cont_q = 1'b0;
         if (k == FRAME_BITS_DEF - 1)
            o_fsc = 1'b1;
      end
   end
endmodule // dca_tdm_model

//--- test_d_channel_access_arbiter.sv
// Self-checking bench for the D-channel access arbiter.
// Assumes dca_pkg, the design files and dca_tdm_model compiled first.
`timescale 1ns/1ps
module test_d_channel_access_arbiter import dca_pkg::*; ;
   logic i_clk, i_srst, i_s_dvalid, i_s_dbit, m_req, m_dval;
   logic [2:0] m_addr;
   dca_cfg_t i_cfg;
   logic dcl, fsc, du_wire, o_du, o_du_oe_n, o_dd, o_s_dready;
   logic o_stop_go, o_tic_owned;
   logic [6:0] idx;
   dca_echo_t o_echo;
   dca_arb_t o_state;
   int error_cnt = 0;
   int compares = 0;
   int cyc_cnt = 0;

   dca_arbiter #(.FRAME_BITS(FRAME_BITS_DEF)) dca_arbiter_i (
      .i_clk(i_clk), .i_srst(i_srst), .i_dcl(dcl), .i_fsc(fsc),
      .i_du(du_wire), .o_du(o_du), .o_du_oe_n(o_du_oe_n), .o_dd(o_dd),
      .i_cfg(i_cfg), .i_s_dvalid(i_s_dvalid), .i_s_dbit(i_s_dbit),
      .o_s_dready(o_s_dready), .o_echo(o_echo), .o_stop_go(o_stop_go),
      .o_tic_owned(o_tic_owned), .o_state(o_state));
   dca_tdm_model dca_tdm_model_i (
      .i_du_oe_n(o_du_oe_n), .i_du(o_du), .i_req(m_req), .i_addr(m_addr),
      .i_dval(m_dval), .o_dcl(dcl), .o_fsc(fsc), .o_wire(du_wire),
      .o_idx(idx));

   always #4 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      cyc_cnt++;
      if (cyc_cnt == 40000) begin
         error_cnt++;
         print_verdict();
      end
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic print_verdict();
      if (error_cnt == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [3:0] seen,
                      input logic [3:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task automatic wait_bit(input int b);
      int g;
      g = 0;
      while (idx == 7'(b) && g < 2000) begin
         step(1);
         g++;
      end
      while (!(idx == 7'(b) && !dcl) && g < 2000) begin
         step(1);
         g++;
      end
      if (g >= 2000) begin
         error_cnt++;
         print_verdict();
      end
      step(3);
   endtask
   task automatic wait_frames(input int n);
      repeat (n) wait_bit(0);
   endtask
   task automatic wait_echo();
      int g;
      g = 0;
      while (o_echo.valid !== 1'b1 && g < 2000) begin
         step(1);
         g++;
      end
      if (g >= 2000) begin
         error_cnt++;
         print_verdict();
      end
   endtask
   task automatic push(input logic b);
      i_s_dvalid = 1'b1;
      i_s_dbit = b;
      while (o_s_dready !== 1'b1) step(1);
      step(1);
   endtask
   task automatic do_reset();
      i_srst = 1'b1;
      step(2);
      i_srst = 1'b0;
      step(1);
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      do_reset();
      chk("stop_go", o_stop_go, 1'b1);
      chk("state", o_state, ST_READY);
      chk("oe_n", o_du_oe_n, 1'b1);
      chk("dd", o_dd, 1'b1);
      for (int b = TBA_IDX0; b < TBA_IDX0 + TBA_W; b++) begin
         wait_bit(b);
         chk("addr_idle", du_wire, 1'b1);
      end
   endtask
   task automatic t_tic_win();
      i_cfg.addr = 3'h3;
      i_cfg.bac_req = 1'b1;
      wait_frames(2);
      chk("owned", o_tic_owned, 1'b1);
      wait_bit(BAC_IDX);
      chk("bac_low", du_wire, 1'b0);
      i_cfg.bac_req = 1'b0;
      wait_frames(1);
      wait_bit(TBA_IDX0);
      chk("released", o_tic_owned, 1'b0);
      i_cfg.bac_req = 1'b1;
      repeat (2) begin
         wait_bit(TBA_IDX0);
         chk("low_prio", o_du_oe_n, 1'b1);
      end
      wait_bit(TBA_IDX0);
      chk("recontend", o_du_oe_n, 1'b0);
      i_cfg.bac_req = 1'b0;
   endtask
   task automatic t_tic_loss();
      do_reset();
      i_cfg.addr = 3'h2;
      i_cfg.bac_req = 1'b1;
      m_req = 1'b1;
      m_addr = 3'h1;
      wait_frames(1);
      wait_bit(TBA_IDX0);
      chk("contend", o_du_oe_n, 1'b0);
      wait_bit(TBA_IDX0 + 2);
      chk("withdraw", o_du_oe_n, 1'b1);
      wait_frames(1);
      chk("lost", o_tic_owned, 1'b0);
      m_req = 1'b0;
      i_cfg.bac_req = 1'b0;
   endtask
   task automatic t_local();
      do_reset();
      i_cfg.inhibit = 1'b1;
      wait_frames(3);
      chk("below_n", o_state, ST_READY);
      wait_frames(5);
      chk("local", o_state, ST_LOCAL);
      chk("go", o_stop_go, 1'b0);
      wait_bit(SG_IDX);
      chk("dd_go", o_dd, 1'b0);
      chk("no_bac", du_wire, 1'b1);
      wait_echo();
      chk("echo_inv", o_echo.value, 1'b0);
      i_cfg.inhibit = 1'b0;
      step(3);
      chk("ready", o_state, ST_READY);
      chk("stop", o_stop_go, 1'b1);
      wait_echo();
      chk("echo_plain", o_echo.value, 1'b1);
      i_cfg.mode = 3'h5;
      i_cfg.inhibit = 1'b1;
      i_cfg.bac_req = 1'b1;
      wait_bit(SG_IDX);
      chk("mode_off", o_state, ST_READY);
      chk("dd_off", o_dd, 1'b1);
      wait_bit(TBA_IDX0);
      chk("no_tic", o_du_oe_n, 1'b1);
      i_cfg.bac_req = 1'b0;
      i_cfg.mode = 3'h1;
      i_cfg.s_reset = 1'b1;
      wait_frames(1);
      chk("s_reset", o_stop_go, 1'b1);
      i_cfg.s_reset = 1'b0;
      i_cfg.s_disable = 1'b1;
      wait_frames(1);
      chk("s_disable", o_state, ST_READY);
      i_cfg.s_disable = 1'b0;
      i_cfg.inhibit = 1'b0;
   endtask
   task automatic t_sacc();
      do_reset();
      push(1'b0);
      i_s_dvalid = 1'b0;
      step(1);
      chk("stray_zero", o_state, ST_READY);
      wait_frames(2);
      push(1'b0);
      push(1'b1);
      chk("buf_full", o_s_dready, 1'b0);
      i_s_dvalid = 1'b0;
      step(2);
      chk("sacc", o_state, ST_SACC);
      wait_bit(D_SLOT_FIRST);
      chk("pass_0", du_wire, 1'b0);
      wait_bit(D_SLOT_FIRST + 1);
      chk("pass_1", du_wire, 1'b1);
      wait_frames(1);
      chk("buf_empty", o_s_dready, 1'b1);
   endtask

   initial begin
      i_clk = 1'b0;
      i_srst = 1'b1;
      i_cfg = '0;
      i_cfg.mode = 3'h1;
      i_s_dvalid = 1'b0;
      i_s_dbit = 1'b0;
      m_req = 1'b0;
      m_addr = 3'h7;
      m_dval = 1'b1;
      step(2);
      i_srst = 1'b0;
      t_reset();
      t_tic_win();
      t_tic_loss();
      t_local();
      t_sacc();
      print_verdict();
   end
endmodule // test_d_channel_access_arbiter
